// [hdl/trb_dbg.sv]
// Trace store readout, opcode tagging and breakpoint request logic
`timescale 1ns/1ns
module trb_dbg (
  input wire logic CLK,
  input wire logic RST_N,
  input wire trb_pkg::trb_req_t REG_REQ,
  output logic [15:0] REG_RDATA,
  input wire trb_pkg::trb_bus_t BUS,
  input wire logic SECURED,
  input wire logic BGD_ACTIVE,
  input wire logic [3:0] CMP_ADDR_MATCH,
  input wire logic [3:0] CMP_FULL_MATCH,
  input wire logic QUEUE_LOAD,
  input wire logic QUEUE_EXEC,
  input wire logic FINAL_ENTRY,
  input wire logic [3:0] FINAL_CHAN,
  output logic [3:0] IMM_SOFTWARE_FORCE_EVENT,
  output logic [3:0] TAG_HIT,
  output logic BRK_REQ,
  output logic ARMED,
  output logic TRACING
);
  import trb_pkg::*;

  //
  // Register port behaviour
  //   Writes land at the strobe edge
  //   Reads answer one cycle after the strobe
  //   Read data holds until the next read
  //   Unmapped reads give zero
  //   Unmapped writes are dropped
  //   Strobes never coincide, so no read races a rewind
  //
  // Trace port high word
  //   Aligned write rewinds the readout pointer
  //   Aligned write while disarmed also unlocks
  //   Aligned read returns the next word
  //   Byte or odd reads return zero
  //   Refused reads leave the pointer alone
  //
  // Readout gate
  //   Module disarmed
  //   Trace source selected
  //   System not secured
  //   Store unlocked since the last arm
  //
  // Line order on readout
  //   Bits 15:0 first, then 31:16
  //   Then 47:32, then 63:48
  //   Then the next line, oldest first
  //   Pointer wraps after the last line
  //
  // Line layout in the store
  //   Top bit always zero
  //   Bus address below it
  //   One empty byte
  //   Data word, byte data in the low half
  //   Info byte: size and direction
  //   Low byte always zero
  //
  // Limitation
  //   Only detail capture is built
  //   Other capture modes need their own line packer
  //

  // Control and status flip-flops
  logic [15:0] ctl_ff;
  logic locked_ff;
  logic tracing_ff;
  logic post_act_ff;
  logic [6:0] post_cnt_ff;
  logic brk_ff;
  logic [3:0] imm_ff;
  logic [3:0] hit_ff;
  logic [15:0] rdata_ff;
  // Storage and its bookkeeping, none of it reset
  logic [63:0] mem [LINES];
  logic [LINE_AW-1:0] wr_ptr_ff;
  logic [6:0] count_ff;
  logic ovf_ff;
  // Readout pointer
  logic [LINE_AW-1:0] rd_line_ff;
  logic [1:0] rd_word_ff;
  // Tag queue, one channel vector per slot
  logic [NCMP-1:0] tq_ff [QDEPTH];
  logic [1:0] tq_fill_ff;

  // Control field decode
  wire arm = ctl_ff[CTL_ARM_BIT];
  wire src_sel = ctl_ff[CTL_SRC_BIT];
  wire detail = ctl_ff[CTL_DETAIL_BIT];
  wire [1:0] align = ctl_ff[CTL_ALIGN_LO +: 2];
  wire brk_en = ctl_ff[CTL_BRKEN_BIT];
  wire [NCMP-1:0] tag_sel = ctl_ff[CTL_TAGSEL_LO +: NCMP];
  wire [NCMP-1:0] halt_sel = ctl_ff[CTL_HALTSEL_LO +: NCMP];

  // Offset match for a register port access
  function automatic logic ofs_hit(input logic [3:0] a, input logic [3:0] ofs);
    ofs_hit = (a == ofs);
  endfunction

  // Register port decode
  wire aligned = ~REG_REQ.byte_acc & ~REG_REQ.addr[0];
  wire wr_ctl = REG_REQ.wr & ofs_hit(REG_REQ.addr, DEBUG_CONTROL_OFS);
  wire wr_tbh = REG_REQ.wr & aligned & ofs_hit(REG_REQ.addr, TRACE_PORT_HIGH_OFS);
  wire rd_tb = REG_REQ.rd & (ofs_hit(REG_REQ.addr, TRACE_PORT_HIGH_OFS)
    | ofs_hit(REG_REQ.addr, TRACE_PORT_LOW_OFS));
  wire arm_start = wr_ctl & REG_REQ.wdata[CTL_ARM_BIT] & ~arm;
  wire [LINE_AW-1:0] oldest = ovf_ff ? wr_ptr_ff : '0;
  wire unlock = wr_tbh & ~arm;
  wire rd_ok = rd_tb & aligned & ~arm & src_sel & ~SECURED & ~locked_ff;

  // Trace entry qualification and line assembly
  wire trace_cycle = BUS.valid & ~BUS.opfetch & ~BUS.free;
  wire trace_wr = arm & tracing_ff & src_sel & detail & trace_cycle;
  wire [7:0] info_byte = {1'b0, BUS.byte_acc, BUS.rd, 5'h00};
  wire [15:0] data_w = BUS.byte_acc ? {8'h00, BUS.data[7:0]} : BUS.data;
  wire [63:0] line_w = {1'b0, BUS.addr, 8'h00, data_w, info_byte, 8'h00};

  // Final state handling
  wire fin = FINAL_ENTRY & arm;
  wire halt_now = |(halt_sel & FINAL_CHAN);
  wire fin_stop = fin & (halt_now | ~src_sel | (align == ALIGN_END));
  wire fin_brk = fin_stop & brk_en;
  wire post_done = post_act_ff & trace_wr & (post_cnt_ff == 7'h01);
  wire buf_full_begin = post_act_ff & trace_wr & (count_ff == FULL_LINES - 7'h01)
    & (align == ALIGN_BEGIN);
  wire sess_end = post_done | buf_full_begin;

  // Tag queue decode: head slot, filtered by background debug
  wire [NCMP-1:0] cmp_tag = CMP_ADDR_MATCH & tag_sel & {NCMP{~BGD_ACTIVE}};
  wire [NCMP-1:0] cmp_imm = CMP_FULL_MATCH & ~tag_sel;
  wire [NCMP-1:0] head_tag = (tq_fill_ff != 2'h0) ? tq_ff[0] : '0;
  wire [NCMP-1:0] hit_w = QUEUE_EXEC & ~BGD_ACTIVE ? head_tag : '0;

  // Readout word selection, low word of the line first
  wire [63:0] rd_line_w = mem[rd_line_ff];
  wire [15:0] rd_word_w = rd_line_w[{rd_word_ff, 4'h0} +: 16];

  // Status view
  wire [15:0] status_w = {12'h000, tracing_ff, ovf_ff, locked_ff, arm};
  wire [15:0] rd_mux = rd_tb ? (rd_ok ? rd_word_w : 16'h0000)
    : ofs_hit(REG_REQ.addr, LINE_COUNT_OFS) ? {9'h000, count_ff}
    : ofs_hit(REG_REQ.addr, DEBUG_CONTROL_OFS) ? ctl_ff
    : ofs_hit(REG_REQ.addr, STATUS_OFS) ? status_w : 16'h0000;

  //
  // Final state handling
  //   Halt select hit: stop tracing now
  //   No trace source: stop now
  //   End alignment: stop now
  //   Any stop breaks next cycle if enabled
  //
  // Begin alignment
  //   Tracing opens at the final state
  //   Session ends when the store is full
  //   Break request follows the last line
  //
  // Mid alignment
  //   Tracing already open since arm
  //   Counts a further run of lines
  //   Break request follows the last one
  //
  // Reserved alignment
  //   Traces from arm, no post count
  //   Ended by software disarm, or at the final state by halt select or no source
  //
  // Hazard: a control write in the stop cycle
  //   Software write wins over hardware disarm
  //   so a fresh arm is never lost
  //

  // Control register: software writes, hardware disarms at session end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctl_ff <= CTL_RESET;
    end else if (wr_ctl) begin
      ctl_ff <= REG_REQ.wdata;
    end else if (fin_stop | sess_end) begin
      ctl_ff[CTL_ARM_BIT] <= 1'b0;
    end
  end

  // Readout lock
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      locked_ff <= 1'b1;
    end else if (arm_start) begin
      locked_ff <= 1'b1;
    end else if (unlock) begin
      locked_ff <= 1'b0;
    end
  end

  // Tracing window and post-trigger line counter
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tracing_ff <= 1'b0;
      post_act_ff <= 1'b0;
      post_cnt_ff <= 7'h00;
    end else if (arm_start) begin
      tracing_ff <= (REG_REQ.wdata[CTL_ALIGN_LO +: 2] != ALIGN_BEGIN);
      post_act_ff <= 1'b0;
    end else if (fin_stop | sess_end | (wr_ctl & ~REG_REQ.wdata[CTL_ARM_BIT])) begin
      tracing_ff <= 1'b0;
      post_act_ff <= 1'b0;
    end else if (fin & ~post_act_ff & (align == ALIGN_BEGIN)) begin
      tracing_ff <= 1'b1;
      post_act_ff <= 1'b1;
      post_cnt_ff <= FULL_LINES;
    end else if (fin & ~post_act_ff & (align == ALIGN_MID)) begin
      post_act_ff <= 1'b1;
      post_cnt_ff <= MID_LINES;
    end else if (post_act_ff & trace_wr) begin
      post_cnt_ff <= post_cnt_ff - 7'h01;
    end
  end

  // Breakpoint request, one cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      brk_ff <= 1'b0;
    end else begin
      brk_ff <= fin_brk | (sess_end & brk_en);
    end
  end

  // Trace storage, kept over system reset
  always_ff @(posedge CLK) begin
    if (trace_wr) begin
      mem[wr_ptr_ff] <= line_w;
    end
  end

  // Write pointer, line count and overflow, kept over system reset
  always_ff @(posedge CLK) begin
    if (arm_start) begin
      wr_ptr_ff <= '0;
      count_ff <= 7'h00;
      ovf_ff <= 1'b0;
    end else if (trace_wr) begin
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (count_ff == FULL_LINES) begin
        ovf_ff <= 1'b1;
      end else begin
        count_ff <= count_ff + 7'h01;
      end
    end
  end

  // Readout pointer: rewound by any aligned high word write, advanced by good reads only
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_line_ff <= '0;
      rd_word_ff <= 2'h0;
    end else if (wr_tbh) begin
      rd_line_ff <= oldest;
      rd_word_ff <= 2'h0;
    end else if (rd_ok) begin
      rd_word_ff <= rd_word_ff + 2'h1;
      if (rd_word_ff == 2'h3) begin
        rd_line_ff <= rd_line_ff + 1'b1;
      end
    end
  end

  // Read data register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_ff <= 16'h0000;
    end else if (REG_REQ.rd) begin
      rdata_ff <= rd_mux;
    end
  end

  //
  // Tag queue behaviour
  //   One slot per queued opcode
  //   Each slot holds one bit per comparator
  //   Load writes the next free slot
  //   Execute shifts every slot toward the head
  //   Load with execute writes one slot lower
  //   Fill level stays put on load with execute
  //
  // Background debug
  //   Empties the queue at once
  //   Masks new tags on load
  //   Masks hits at the head
  //
  // Limitation
  //   A load into a full queue is dropped
  //   Queue depth must match the core
  //
  // Hazard: stale slots after a flush
  //   Fill level gates the head slot,
  //   so old contents never hit
  //

  // Tag queue: push on opcode load, pop on execute, flushed in background debug
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tq_fill_ff <= 2'h0;
    end else if (BGD_ACTIVE) begin
      tq_fill_ff <= 2'h0;
    end else if (QUEUE_LOAD & ~QUEUE_EXEC & (tq_fill_ff != 2'(QDEPTH))) begin
      tq_fill_ff <= tq_fill_ff + 2'h1;
    end else if (~QUEUE_LOAD & QUEUE_EXEC & (tq_fill_ff != 2'h0)) begin
      tq_fill_ff <= tq_fill_ff - 2'h1;
    end
  end

  // Tag slots shift toward the head
  generate
    for (genvar i = 0; i < QDEPTH; i++) begin : g_tq
      wire [1:0] slot = 2'(i);
      wire [1:0] wr_slot = QUEUE_EXEC ? tq_fill_ff - 2'h1 : tq_fill_ff;
      wire [NCMP-1:0] above = (i + 1 < QDEPTH) ? tq_ff[(i + 1) % QDEPTH] : '0;
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          tq_ff[i] <= '0;
        end else if (QUEUE_LOAD & (slot == wr_slot)) begin
          tq_ff[i] <= cmp_tag;
        end else if (QUEUE_EXEC) begin
          tq_ff[i] <= above;
        end
      end
    end
  endgenerate

  // Trigger outputs to the sequencer
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      imm_ff <= '0;
      hit_ff <= '0;
    end else begin
      imm_ff <= cmp_imm;
      hit_ff <= hit_w;
    end
  end

  //
  // Output notes
  //   Every output comes from a flip-flop
  //   Break request is a one cycle pulse
  //   Tag hits are one cycle pulses
  //   Immediate triggers lag matches by one cycle
  //   Armed mirrors the control arm bit
  //   Tracing shows the open capture window
  //
  // Reset notes
  //   Control, lock, pointer and queue reset
  //   Store, count, write pointer and overflow kept
  //   So a session cut by reset can be read back
  //   Unlock after reset finds the oldest line
  //

  assign REG_RDATA = rdata_ff;
  assign IMM_SOFTWARE_FORCE_EVENT = imm_ff;
  assign TAG_HIT = hit_ff;
  assign BRK_REQ = brk_ff;
  assign ARMED = ctl_ff[CTL_ARM_BIT];
  assign TRACING = tracing_ff;
endmodule // trb_dbg

// [hdl/trb_pkg.sv]
// Constants, types and register map of the trace readout, tag and breakpoint block
// Function
// - Detail info byte bit 6 is 1 for byte access, 0 for word.
// - Detail info byte bit 5 is 1 for read, 0 for write.
// - Detail mode stores every bus cycle except opcode fetch and free cycles.
// - Readout only while disarmed, tracing configured and not secured.
// - Arming locks readout; aligned word write to the port unlocks while disarmed.
// - Byte or misaligned port reads return zero and keep the pointer.
// - Lines come out oldest first; line count never drops on reads.
// - After a session the pointer sits on line zero or the oldest line; the code moves it only on an aligned high word write or a good read.
// - Each aligned write to the high word rewinds the pointer to oldest.
// - Low word of each line comes first; invalid bytes are read too.
// - Reads while armed give invalid data and do not advance.
// - Reset keeps lines and count; unlocking finds the oldest entry.
// - Tags ride the instruction queue and hit at the queue head.
// - Per comparator select: immediate trigger or opcode tag.
// - Begin alignment: final state starts tracing, break after completion.
// - Mid alignment: 32 more lines after the trigger, then break.
// - End alignment: break at once when final state is reached.
// - Tagged comparators ignore access qualifiers; ranges word accurate.
// - All tagging off while background debug is active.
// - Break after session if tracing selected, otherwise at once.
// - Immediate halt select stops tracing and breaks at once if enabled.
// - Alignment 00 end, 01 begin, 10 mid, 11 reserved.
package trb_pkg;
  // Register port byte offsets
  localparam logic [3:0] TRACE_PORT_HIGH_OFS = 4'h0;
  localparam logic [3:0] TRACE_PORT_LOW_OFS = 4'h1;
  localparam logic [3:0] LINE_COUNT_OFS = 4'h2;
  localparam logic [3:0] DEBUG_CONTROL_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h6;
  // Control register fields
  localparam int CTL_ARM_BIT = 0;
  localparam int CTL_SRC_BIT = 1;
  localparam int CTL_DETAIL_BIT = 2;
  localparam int CTL_ALIGN_LO = 3;
  localparam int CTL_BRKEN_BIT = 5;
  localparam int CTL_TAGSEL_LO = 8;
  localparam int CTL_HALTSEL_LO = 12;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  // Detail info byte fields
  localparam int INFO_SIZE_BIT = 6;
  localparam int INFO_RW_BIT = 5;
  // Storage geometry and counts
  localparam int LINES = 64;
  localparam int LINE_AW = 6;
  localparam logic [6:0] FULL_LINES = 7'h40;
  localparam logic [6:0] MID_LINES = 7'h20;
  localparam int NCMP = 4;
  localparam int QDEPTH = 3;
  // Trigger alignment encodings
  typedef enum logic [1:0] {
    ALIGN_END = 2'b00,
    ALIGN_BEGIN = 2'b01,
    ALIGN_MID = 2'b10,
    ALIGN_RSVD = 2'b11
  } trb_align_t;
  // One processor bus cycle offered for tracing
  typedef struct packed {
    logic valid;
    logic opfetch;
    logic free;
    logic rd;
    logic byte_acc;
    logic [22:0] addr;
    logic [15:0] data;
  } trb_bus_t;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic byte_acc;
    logic [3:0] addr;
    logic [15:0] wdata;
  } trb_req_t;
endpackage

// [tb/trb_cpu_model.sv]
// Processor bus model issuing a random mix of bus cycles
`timescale 1ns/1ns
module trb_cpu_model (
  input wire logic CLK,
  input wire logic EN,
  output trb_pkg::trb_bus_t BUS
);
  import trb_pkg::*;
  logic [15:0] lf = 16'hACE1;
  initial BUS = '0;
  // Fetch and free cycles mixed in among data cycles
  always @(posedge CLK) begin
    lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    BUS <= '{EN, lf[0] & lf[1], lf[2] & lf[3], lf[4], lf[5], {lf[6:0], lf}, ~lf};
  end
endmodule // trb_cpu_model

// [tb/trb_dbg_sva.sv]
// Checker for the trace readout, tag and breakpoint block
`timescale 1ns/1ns
module trb_dbg_sva (
  input wire logic CLK,
  input wire logic RST_N,
  input wire trb_pkg::trb_req_t REG_REQ,
  input wire logic [15:0] REG_RDATA,
  input wire logic SECURED,
  input wire logic BGD_ACTIVE,
  input wire logic [3:0] CMP_FULL_MATCH,
  input wire logic QUEUE_EXEC,
  input wire logic FINAL_ENTRY,
  input wire logic [3:0] FINAL_CHAN,
  input wire logic [3:0] IMM_SOFTWARE_FORCE_EVENT,
  input wire logic [3:0] TAG_HIT,
  input wire logic BRK_REQ,
  input wire logic ARMED,
  input wire logic TRACING
);
  import trb_pkg::*;
  logic [15:0] ctl_ff;
  // Decoded conditions
  wire logic [3:0] tsel = ctl_ff[11:8];
  wire logic trd = REG_REQ.rd && REG_REQ.addr == TRACE_PORT_HIGH_OFS;
  wire logic fin = FINAL_ENTRY && ARMED;
  wire logic hit = (FINAL_CHAN & ctl_ff[15:12]) != 4'h0;
  // Shadow of the control word
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) ctl_ff <= 16'h0000;
    else if (REG_REQ.wr && REG_REQ.addr == DEBUG_CONTROL_OFS) ctl_ff <= REG_REQ.wdata;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  AST_BRK_PULSE: assert property (BRK_REQ |=> !BRK_REQ) else $error("long break");
  AST_ARMED_RD: assert property (trd && ARMED |=> REG_RDATA == 16'h0000)
    else $error("armed read data");
  AST_SEC_RD: assert property (trd && SECURED |=> REG_RDATA == 16'h0000)
    else $error("secured read data");
  AST_BYTE_RD: assert property (REG_REQ.rd && REG_REQ.addr[3:1] == 3'h0 &&
    (REG_REQ.byte_acc || REG_REQ.addr[0]) |=> REG_RDATA == 16'h0000) else $error("byte read");
  AST_TAG_EXEC: assert property (TAG_HIT != 4'h0 |-> $past(QUEUE_EXEC) &&
    !$past(BGD_ACTIVE)) else $error("stray tag hit");
  AST_TAG_BGD: assert property (BGD_ACTIVE |=> TAG_HIT == 4'h0)
    else $error("tag in background debug");
  AST_IMM: assert property ((IMM_SOFTWARE_FORCE_EVENT & ($past(tsel) | ~$past(CMP_FULL_MATCH))) == 4'h0)
    else $error("bad trigger");
  AST_END_BRK: assert property (fin && ctl_ff[5] && ctl_ff[4:3] == 2'b00 |=> BRK_REQ)
    else $error("end break late");
  AST_NOSRC_BRK: assert property (fin && ctl_ff[5] && !ctl_ff[1] |=> BRK_REQ)
    else $error("no source break late");
  AST_HALT: assert property (fin && hit |=> !TRACING && (BRK_REQ || !ctl_ff[5]))
    else $error("halt select ignored");
  AST_BEGIN: assert property (fin && ctl_ff[1] && ctl_ff[4:3] == 2'b01 && !hit |=>
    TRACING && !BRK_REQ) else $error("begin trace not started");
  // Main scenarios reached
  cover property (fin ##1 BRK_REQ);
  cover property (TAG_HIT != 4'h0);
  cover property (trd && ARMED);
endmodule // trb_dbg_sva
bind trb_dbg trb_dbg_sva u_sva (.CLK, .RST_N, .REG_REQ, .REG_RDATA, .SECURED, .BGD_ACTIVE,
  .CMP_FULL_MATCH, .QUEUE_EXEC, .FINAL_ENTRY, .FINAL_CHAN, .IMM_SOFTWARE_FORCE_EVENT, .TAG_HIT, .BRK_REQ,
  .ARMED, .TRACING);

// [tb/trb_dbg_tb.sv]
// Self-checking bench for the trace readout, tag and breakpoint block
`timescale 1ns/1ns
module trb_dbg_tb;
  import trb_pkg::*;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  trb_req_t REG_REQ = '0;
  trb_bus_t BUS;
  logic SECURED = 1'b0;
  logic BGD_ACTIVE = 1'b0;
  logic [3:0] CMP_ADDR_MATCH = 4'h0;
  logic [3:0] CMP_FULL_MATCH = 4'h0;
  logic QUEUE_LOAD = 1'b0;
  logic QUEUE_EXEC = 1'b0;
  logic FINAL_ENTRY = 1'b0;
  logic [3:0] FINAL_CHAN = 4'h0;
  logic [15:0] REG_RDATA;
  logic [3:0] IMM_SOFTWARE_FORCE_EVENT, TAG_HIT;
  logic BRK_REQ, ARMED, TRACING;
  logic [63:0] q[$];
  logic [15:0] r = 16'h0881;
  logic [15:0] c = 16'h0000;
  int num_errors = 0;
  int num_checks = 0;
  int post = 0;
  int cyc = 0;
  trb_dbg u_dut (.CLK, .RST_N, .REG_REQ, .REG_RDATA, .BUS, .SECURED, .BGD_ACTIVE,
    .CMP_ADDR_MATCH, .CMP_FULL_MATCH, .QUEUE_LOAD, .QUEUE_EXEC, .FINAL_ENTRY, .FINAL_CHAN,
    .IMM_SOFTWARE_FORCE_EVENT, .TAG_HIT, .BRK_REQ, .ARMED, .TRACING);
  trb_cpu_model u_cpu (.CLK, .EN(RST_N), .BUS);
  always #25 CLK = ~CLK;
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Expected line for one bus cycle
  function automatic logic [63:0] line(input trb_bus_t b);
    return {1'b0, b.addr, 8'h00, b.byte_acc ? {8'h00, b.data[7:0]} : b.data,
      1'b0, b.byte_acc, b.rd, 5'h00, 8'h00};
  endfunction
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Trace store model and hang limit
  always @(posedge CLK) begin
    if (cyc++ > 30000) begin
      num_errors++;
      final_report();
    end
    if (ARMED && TRACING && c[1] && BUS.valid && !BUS.opfetch && !BUS.free) begin
      q.push_back(line(BUS));
      post++;
      if (q.size() > 64) void'(q.pop_front());
    end
  end
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    REG_REQ <= '{1'b1, 1'b0, 1'b0, a, d};
    @(posedge CLK);
    REG_REQ <= '0;
    @(posedge CLK);
  endtask
  task automatic rdc(input logic [3:0] a, input logic b, input logic [15:0] e);
    REG_REQ <= '{1'b0, 1'b1, b, a, 16'h0000};
    @(posedge CLK);
    REG_REQ <= '0;
    @(negedge CLK);
    chk(REG_RDATA, e);
    @(posedge CLK);
  endtask
  task automatic dump;
    wr(TRACE_PORT_HIGH_OFS, 16'h0000);
    foreach (q[i]) for (int w = 0; w < 4; w++) rdc(4'h0, 1'b0, q[i][16*w+:16]);
  endtask
  task automatic tags(input logic b);
    logic [3:0] t[3];
    BGD_ACTIVE <= b;
    for (int i = 0; i < 3; i++) begin
      r = nx(r);
      t[i] = r[3:0];
      CMP_ADDR_MATCH <= t[i];
      CMP_FULL_MATCH <= r[7:4];
      QUEUE_LOAD <= 1'b1;
      @(posedge CLK);
    end
    QUEUE_LOAD <= 1'b0;
    QUEUE_EXEC <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge CLK);
      if (i == 2) QUEUE_EXEC <= 1'b0;
      @(negedge CLK);
      chk({IMM_SOFTWARE_FORCE_EVENT, TAG_HIT}, {4'h0, b ? 4'h0 : t[i]});
    end
    @(posedge CLK);
    BGD_ACTIVE <= 1'b0;
    @(posedge CLK);
  endtask
  // Sessions in end, mid and begin alignment, readout, reset retention, tagging
  initial begin
    logic [15:0] cs[4];
    int pe[4];
    int k;
    cs = '{16'h0025, 16'h1027, 16'h0037, 16'h002F};
    pe = '{0, 0, 32, 64};
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    for (int i = 0; i < 4; i++) begin
      c = cs[i];
      q.delete();
      wr(DEBUG_CONTROL_OFS, c);
      rdc(TRACE_PORT_HIGH_OFS, 1'b0, 16'h0000);
      r = nx(r);
      repeat (20 + r[7:0]) @(posedge CLK);
      FINAL_ENTRY <= 1'b1;
      FINAL_CHAN <= 4'h1;
      @(posedge CLK);
      FINAL_ENTRY <= 1'b0;
      k = 0;
      do begin
        @(negedge CLK);
        if (k == 0) post = 0;
        k++;
      end while (BRK_REQ !== 1'b1 && k < 2000);
      chk(post, pe[i]);
      if (i < 2) chk(k, 1);
      @(posedge CLK);
      rdc(TRACE_PORT_HIGH_OFS, 1'b0, 16'h0000);
      rdc(LINE_COUNT_OFS, 1'b0, 16'(q.size()));
      wr(TRACE_PORT_HIGH_OFS, 16'h0000);
      rdc(TRACE_PORT_HIGH_OFS, 1'b1, 16'h0000);
      rdc(TRACE_PORT_LOW_OFS, 1'b0, 16'h0000);
      if (!c[1]) rdc(TRACE_PORT_HIGH_OFS, 1'b0, 16'h0000);
      dump();
    end
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    @(negedge CLK);
    chk({ARMED, TRACING, BRK_REQ, TAG_HIT, IMM_SOFTWARE_FORCE_EVENT}, 64'h0);
    @(posedge CLK);
    wr(DEBUG_CONTROL_OFS, 16'h0006);
    rdc(LINE_COUNT_OFS, 1'b0, 16'h0040);
    dump();
    SECURED <= 1'b1;
    wr(TRACE_PORT_HIGH_OFS, 16'h0000);
    rdc(TRACE_PORT_HIGH_OFS, 1'b0, 16'h0000);
    SECURED <= 1'b0;
    wr(DEBUG_CONTROL_OFS, 16'h0F01);
    tags(1'b0);
    tags(1'b1);
    wr(DEBUG_CONTROL_OFS, 16'h0001);
    CMP_FULL_MATCH <= 4'h5;
    @(posedge CLK);
    @(negedge CLK);
    chk(IMM_SOFTWARE_FORCE_EVENT, 4'h5);
    final_report();
  end
endmodule // trb_dbg_tb
